// ### rtl/fspag_guard.sv
// Access guard and stall control for flash self-programming
`timescale 1ns/1ns
`default_nettype none
`include "fspag_consts.svh"

// How it works
// R01: Program requests from application code are refused.
// R02: Boot code may program any page, boot pages included, if protection allows.
// R03: Boot boundary follows the boot size setting input.
// R04: Concurrent-region programming keeps CPU running; only stalling-region reads allowed.
// R05: Stalling-region programming halts the CPU for the whole operation.
// R06: Software must not read the concurrent region while it is busy.
// R07: Software should mask interrupts or move vectors to boot while busy.
// R08: Boot section always lies inside the stalling region.
// R09: Region busy flag is one while the concurrent region is blocked.
// R10: Software clears the busy flag before using concurrent-region code again.
// R11: Busy clears on re-enable after completion, or on a buffer load.
// R12: Two separate protection fields, application and boot.
// R13: Protection bits only go programmed; chip erase restores them. Here sys_rst_i restores them too.
// R14: Lock mode 2 never blocks store-program writes.
// R15: Lock mode 3 never blocks program loads or store-program writes.
// R16: Field 11 imposes no restriction.
// R17: Application field 10 or 00 blocks writes to application.
// R18: Application field 00 or 01 blocks boot loads from application.
// R19: Application field 00/01 with boot vectors masks interrupts in application.
// R20: Boot field 10 or 00 blocks writes to boot.
// R21: Boot field 00 or 01 blocks application loads from boot.
// R22: Boot field 00/01 with application vectors masks interrupts in boot.
// R23: Stall holds fetch until the flash reports done, then resumes.
module fspag_guard
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	// Configuration
	input wire logic [1:0] boot_size_setting_i,
	input wire logic vectors_in_boot_i,
	input wire logic [1:0] lock_mode_i,
	// Protection field programming
	input wire logic prot_set_i,
	input wire logic [3:0] prot_data_i,
	input wire logic chip_erase_i,
	// CPU side
	input wire logic [6:0] pc_page_i,
	input wire fspag_pkg::fspag_req_type spm_req_i,
	input wire logic lpm_req_i,
	input wire logic [6:0] lpm_page_i,
	input wire logic [6:0] fetch_page_i,
	// Flash side
	input wire logic flash_done_i,
	// Results to CPU and flash
	output logic spm_accept_o,
	output logic spm_refuse_o,
	output fspag_pkg::fspag_req_type flash_cmd_o,
	output logic lpm_allow_o,
	output logic fetch_allow_o,
	output logic cpu_stall_o,
	output logic irq_mask_o,
	output logic region_busy_flag_o,
	output logic [1:0] app_protect_o,
	output logic [1:0] boot_protect_o
);

	// -------------------------------------------------------------------------
	// State
	// -------------------------------------------------------------------------
	typedef struct packed {
		fspag_pkg::fspag_state_type fsm;
		logic [1:0] app_prot;
		logic [1:0] boot_prot;
		logic busy;
		logic accept;
		logic refuse;
		fspag_pkg::fspag_req_type cmd;
		logic lpm_allow;
		logic fetch_allow;
		logic stall;
		logic irq_mask;
	} fspag_state_all_type;

	fspag_state_all_type st;
	fspag_state_all_type next_st;

	logic pc_boot;
	logic tgt_boot;
	logic tgt_stall;
	logic lpm_boot;
	logic lpm_stall;
	logic fetch_stall;

	// -------------------------------------------------------------------------
	// Section decode
	// -------------------------------------------------------------------------
	fspag_section_decode u_pc_dec (
		.page_i(pc_page_i),
		.boot_size_setting_i(boot_size_setting_i),
		.in_boot_o(pc_boot),
		.in_stall_o()
	); // [R03]

	fspag_section_decode u_tgt_dec (
		.page_i(spm_req_i.page),
		.boot_size_setting_i(boot_size_setting_i),
		.in_boot_o(tgt_boot),
		.in_stall_o(tgt_stall)
	);

	fspag_section_decode u_lpm_dec (
		.page_i(lpm_page_i),
		.boot_size_setting_i(boot_size_setting_i),
		.in_boot_o(lpm_boot),
		.in_stall_o(lpm_stall)
	);

	fspag_section_decode u_fetch_dec (
		.page_i(fetch_page_i),
		.boot_size_setting_i(boot_size_setting_i),
		.in_boot_o(),
		.in_stall_o(fetch_stall)
	);

	// -------------------------------------------------------------------------
	// Protection decode
	// -------------------------------------------------------------------------
	function automatic logic write_blocked(input logic [1:0] f);
		write_blocked = (f == `FSPAG_PROT_NOWRITE) || (f == `FSPAG_PROT_LOCKED); // [R17] [R20] [R16]
	endfunction : write_blocked

	function automatic logic read_blocked(input logic [1:0] f);
		read_blocked = (f == `FSPAG_PROT_LOCKED) || (f == `FSPAG_PROT_NOREAD); // [R18] [R21] [R16]
	endfunction : read_blocked

	// -------------------------------------------------------------------------
	// Access and interrupt decode
	// -------------------------------------------------------------------------
	// Erase and write start the array; load and re-enable only touch buffer or flag
	function automatic logic is_program_op(input fspag_pkg::fspag_op_type op);
		is_program_op = (op == fspag_pkg::FSPAG_OP_ERASE) || (op == fspag_pkg::FSPAG_OP_WRITE);
	endfunction : is_program_op

	// Fields only lose bits; a one in the data leaves the bit as it was
	function automatic logic [1:0] field_program(input logic [1:0] cur, input logic [1:0] data);
		field_program = cur & data;
	endfunction : field_program

	// A write is judged by the field of the section it targets
	function automatic logic write_permitted(
		input logic into_boot,
		input logic [1:0] app_f,
		input logic [1:0] boot_f
	);
		write_permitted = into_boot ? !write_blocked(boot_f) : !write_blocked(app_f); // [R17] [R20]
	endfunction : write_permitted

	// A load is judged by the field of the section it reads, never by its own
	function automatic logic load_permitted(
		input logic from_boot,
		input logic into_boot,
		input logic [1:0] app_f,
		input logic [1:0] boot_f
	);
		if (from_boot && !into_boot)
		begin
			load_permitted = !read_blocked(app_f); // [R18] [R15]
		end
		else if (!from_boot && into_boot)
		begin
			load_permitted = !read_blocked(boot_f); // [R21]
		end
		else
		begin
			load_permitted = 1'b1; // [R16]
		end
	endfunction : load_permitted

	// Masking applies only when the vectors sit in the other section
	function automatic logic irq_masked(
		input logic from_boot,
		input logic vec_boot,
		input logic [1:0] app_f,
		input logic [1:0] boot_f
	);
		if (!from_boot && vec_boot)
		begin
			irq_masked = read_blocked(app_f); // [R19]
		end
		else if (from_boot && !vec_boot)
		begin
			irq_masked = read_blocked(boot_f); // [R22]
		end
		else
		begin
			irq_masked = 1'b0;
		end
	endfunction : irq_masked

	// -------------------------------------------------------------------------
	// Next state
	// -------------------------------------------------------------------------
	always_comb
	begin
		logic prog_op;
		logic wr_ok;
		logic busy_now;
		logic lpm_gate;
		prog_op = 1'b0;
		wr_ok = 1'b0;
		busy_now = 1'b0;
		lpm_gate = 1'b0;
		next_st = st;
		next_st.accept = 1'b0;
		next_st.refuse = 1'b0;
		next_st.cmd = '0;

		// Bits only move towards programmed; chip erase and sys_rst_i release them
		if (chip_erase_i)
		begin
			next_st.app_prot = `FSPAG_PROT_FREE; // [R13]
			next_st.boot_prot = `FSPAG_PROT_FREE;
		end
		else if (prot_set_i && pc_boot)
		begin
			next_st.app_prot = field_program(st.app_prot, prot_data_i[1:0]); // [R12] [R13]
			next_st.boot_prot = field_program(st.boot_prot, prot_data_i[3:2]);
		end

		// Lock mode is deliberately not consulted anywhere below
		prog_op = is_program_op(spm_req_i.op);
		wr_ok = write_permitted(tgt_boot, st.app_prot, st.boot_prot); // [R02] [R14] [R15]

		case (st.fsm)
			fspag_pkg::FSPAG_IDLE:
			begin
				if (spm_req_i.valid)
				begin
					// Refusals leave busy and the protection fields untouched
					if (!pc_boot)
					begin
						next_st.refuse = 1'b1; // [R01]
					end
					else if (prog_op && !wr_ok)
					begin
						next_st.refuse = 1'b1;
					end
					else
					begin
						next_st.accept = 1'b1;
						next_st.cmd = spm_req_i;
						if (prog_op && tgt_stall)
						begin
							next_st.fsm = fspag_pkg::FSPAG_BUSY_STALLING_REGION; // [R05]
						end
						else if (prog_op)
						begin
							next_st.fsm = fspag_pkg::FSPAG_BUSY_RWW; // [R04]
							next_st.busy = 1'b1; // [R09]
						end
						else if (spm_req_i.op == fspag_pkg::FSPAG_OP_LOAD)
						begin
							next_st.busy = 1'b0; // [R11]
						end
						else
						begin
							next_st.busy = 1'b0; // [R11]
						end
					end
				end
			end
			fspag_pkg::FSPAG_BUSY_RWW:
			begin
				// Busy must outlive the operation, so re-enable waits for idle
				if (spm_req_i.valid)
				begin
					next_st.refuse = 1'b1;
				end
				if (flash_done_i)
				begin
					next_st.fsm = fspag_pkg::FSPAG_IDLE;
				end
			end
			fspag_pkg::FSPAG_BUSY_STALLING_REGION:
			begin
				// The CPU is frozen here, so no request can arrive
				if (flash_done_i)
				begin
					next_st.fsm = fspag_pkg::FSPAG_IDLE; // [R23]
				end
			end
			default:
			begin
				next_st.fsm = fspag_pkg::FSPAG_IDLE;
			end
		endcase

		busy_now = next_st.busy;
		next_st.stall = (next_st.fsm == fspag_pkg::FSPAG_BUSY_STALLING_REGION); // [R05] [R23]
		// Fetch freezes with the CPU and keeps off the busy region
		next_st.fetch_allow = !next_st.stall && (!busy_now || fetch_stall); // [R04] [R08] [R06]

		// Loads stop with the CPU and keep off the busy region
		lpm_gate = lpm_req_i && !next_st.stall && (!busy_now || lpm_stall); // [R04] [R05]
		if (lpm_gate)
		begin
			next_st.lpm_allow = load_permitted(pc_boot, lpm_boot, st.app_prot, st.boot_prot); // [R18] [R21]
		end
		else
		begin
			next_st.lpm_allow = 1'b0;
		end

		// Interrupt masking by the section the code runs from
		next_st.irq_mask = irq_masked(pc_boot, vectors_in_boot_i, st.app_prot, st.boot_prot); // [R19] [R22]
	end

	// -------------------------------------------------------------------------
	// Registers
	// -------------------------------------------------------------------------
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			st <= '0;
			st.fsm <= fspag_pkg::FSPAG_IDLE;
			st.app_prot <= `FSPAG_PROT_FREE;
			st.boot_prot <= `FSPAG_PROT_FREE;
			// Nothing is pending out of reset, so fetch starts allowed
			st.fetch_allow <= 1'b1;
		end
		else
		begin
			st <= next_st;
		end
	end

	// -------------------------------------------------------------------------
	// Output drive
	// -------------------------------------------------------------------------
	assign spm_accept_o = st.accept;
	assign spm_refuse_o = st.refuse;
	assign flash_cmd_o = st.cmd;
	assign lpm_allow_o = st.lpm_allow;
	assign fetch_allow_o = st.fetch_allow;
	assign cpu_stall_o = st.stall;
	assign irq_mask_o = st.irq_mask;
	assign region_busy_flag_o = st.busy;
	assign app_protect_o = st.app_prot;
	assign boot_protect_o = st.boot_prot;

endmodule : fspag_guard
`default_nettype wire

// ### rtl/fspag_consts.svh
// Constants for the flash self-program access guard
`ifndef FSPAG_CONSTS_SVH
`define FSPAG_CONSTS_SVH

// -----------------------------------------------------------------------------
// Address geometry
// -----------------------------------------------------------------------------
`define FSPAG_ADDR_W 12
`define FSPAG_PAGE_W 7
`define FSPAG_STALLING_REGION_START_PAGE 7'h60
// Boot size setting -> first boot page (setting 11 = smallest section)
`define FSPAG_BOOT_PAGE_SZ0 7'h60
`define FSPAG_BOOT_PAGE_SZ1 7'h70
`define FSPAG_BOOT_PAGE_SZ2 7'h78
`define FSPAG_BOOT_PAGE_SZ3 7'h7c

// -----------------------------------------------------------------------------
// Protection field encodings and reset values
// -----------------------------------------------------------------------------
`define FSPAG_PROT_FREE 2'h3
`define FSPAG_PROT_NOWRITE 2'h2
`define FSPAG_PROT_LOCKED 2'h0
`define FSPAG_PROT_NOREAD 2'h1

`endif

// ### rtl/fspag_pkg.sv
// Types shared by the flash self-program access guard
package fspag_pkg;

	typedef enum logic [1:0] {
		FSPAG_OP_LOAD,
		FSPAG_OP_ERASE,
		FSPAG_OP_WRITE,
		FSPAG_OP_REENABLE
	} fspag_op_type;

	typedef struct packed {
		logic valid;
		fspag_op_type op;
		logic [6:0] page;
	} fspag_req_type;

	typedef enum logic [1:0] {
		FSPAG_IDLE,
		FSPAG_BUSY_RWW,
		FSPAG_BUSY_STALLING_REGION
	} fspag_state_type;

endpackage : fspag_pkg

// ### rtl/fspag_section_decode.sv
// Section decode of a flash page against the boot and stalling-region limits
`timescale 1ns/1ns
`default_nettype none
`include "fspag_consts.svh"

module fspag_section_decode
(
	// Page under test
	input wire logic [6:0] page_i,
	// Boot size setting
	input wire logic [1:0] boot_size_setting_i,
	// Results
	output logic in_boot_o,
	output logic in_stall_o
);

	logic [6:0] boot_start;

	always_comb
	begin
		case (boot_size_setting_i)
			2'h0: boot_start = `FSPAG_BOOT_PAGE_SZ0;
			2'h1: boot_start = `FSPAG_BOOT_PAGE_SZ1;
			2'h2: boot_start = `FSPAG_BOOT_PAGE_SZ2;
			default: boot_start = `FSPAG_BOOT_PAGE_SZ3;
		endcase
	end

	// Every boot start is at or above the stalling start, so boot stays inside it
	assign in_boot_o = page_i >= boot_start;
	assign in_stall_o = page_i >= `FSPAG_STALLING_REGION_START_PAGE;

endmodule : fspag_section_decode
`default_nettype wire

// ### test/fspag_flash_model.sv
// Flash array stand-in that completes erase and write commands
`timescale 1ns/1ns
`default_nettype none
module fspag_flash_model
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	// Command in, completion out
	input wire fspag_pkg::fspag_req_type cmd_i,
	input wire logic [7:0] lat_i,
	output logic done_o
);
logic [7:0] cnt;
always_ff @(posedge mclk_i)
begin
	if (sys_rst_i)
		cnt <= 8'h0;
	else if (cmd_i.valid && (cmd_i.op == fspag_pkg::FSPAG_OP_ERASE || cmd_i.op == fspag_pkg::FSPAG_OP_WRITE))
		cnt <= lat_i;
	else if (cnt != 8'h0)
		cnt <= cnt - 8'h1;
end
// Pulse only, so a missed sample shows up as a hang
assign done_o = (cnt == 8'h1);
endmodule : fspag_flash_model
`default_nettype wire

// ### test/fspag_guard_chk.sv
// Port assertions for the flash self-program access guard
`timescale 1ns/1ns
`default_nettype none
`include "fspag_consts.svh"
module fspag_guard_chk
(
	// Watched ports
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic [1:0] boot_size_setting_i,
	input wire logic [6:0] pc_page_i,
	input wire fspag_pkg::fspag_req_type spm_req_i,
	input wire logic lpm_req_i,
	input wire logic [6:0] lpm_page_i,
	input wire logic flash_done_i,
	input wire logic spm_accept_o,
	input wire fspag_pkg::fspag_req_type flash_cmd_o,
	input wire logic lpm_allow_o,
	input wire logic cpu_stall_o,
	input wire logic region_busy_flag_o,
	input wire logic [1:0] app_protect_o,
	input wire logic [1:0] boot_protect_o
);
logic [6:0] bs;
logic wr;
logic cwr;
always_comb
begin
	case (boot_size_setting_i)
		2'h0: bs = `FSPAG_BOOT_PAGE_SZ0;
		2'h1: bs = `FSPAG_BOOT_PAGE_SZ1;
		2'h2: bs = `FSPAG_BOOT_PAGE_SZ2;
		default: bs = `FSPAG_BOOT_PAGE_SZ3;
	endcase
end
assign wr = spm_req_i.valid && spm_req_i.op inside {fspag_pkg::FSPAG_OP_ERASE, fspag_pkg::FSPAG_OP_WRITE};
assign cwr = spm_accept_o && flash_cmd_o.op inside {fspag_pkg::FSPAG_OP_ERASE, fspag_pkg::FSPAG_OP_WRITE};
default clocking @(posedge mclk_i); endclocking
default disable iff (sys_rst_i);
property p_app_pc; spm_req_i.valid && pc_page_i < bs |=> !spm_accept_o; endproperty
a_app_pc: assert property (p_app_pc) else $error("spm taken from app code");
property p_app_wr; wr && spm_req_i.page < bs && !app_protect_o[0] |=> !spm_accept_o; endproperty
a_app_wr: assert property (p_app_wr) else $error("app write not blocked");
property p_boot_wr; wr && spm_req_i.page >= bs && !boot_protect_o[0] |=> !spm_accept_o; endproperty
a_boot_wr: assert property (p_boot_wr) else $error("boot write not blocked");
property p_app_rd; lpm_req_i && pc_page_i >= bs && lpm_page_i < bs && !app_protect_o[1] |=> !lpm_allow_o; endproperty
a_app_rd: assert property (p_app_rd) else $error("app read not blocked");
property p_stall; cwr && flash_cmd_o.page >= `FSPAG_STALLING_REGION_START_PAGE |-> cpu_stall_o; endproperty
a_stall: assert property (p_stall) else $error("no stall");
property p_resume; cpu_stall_o |=> cpu_stall_o != $past(flash_done_i); endproperty
a_resume: assert property (p_resume) else $error("stall end wrong");
property p_busy; cwr && flash_cmd_o.page < `FSPAG_STALLING_REGION_START_PAGE |-> region_busy_flag_o; endproperty
a_busy: assert property (p_busy) else $error("busy not set");
property p_unbusy; spm_accept_o && flash_cmd_o.op inside {fspag_pkg::FSPAG_OP_LOAD, fspag_pkg::FSPAG_OP_REENABLE}
	|-> ##[0:1] !region_busy_flag_o; endproperty
a_unbusy: assert property (p_unbusy) else $error("busy not cleared");
cover property (cwr && cpu_stall_o);
cover property (wr && !boot_protect_o[0]);
cover property ($fell(region_busy_flag_o));
endmodule : fspag_guard_chk
bind fspag_guard fspag_guard_chk chk_u (.mclk_i, .sys_rst_i, .boot_size_setting_i, .pc_page_i, .spm_req_i,
	.lpm_req_i, .lpm_page_i, .flash_done_i, .spm_accept_o, .flash_cmd_o, .lpm_allow_o, .cpu_stall_o,
	.region_busy_flag_o, .app_protect_o, .boot_protect_o);
`default_nettype wire

// ### test/tb.sv
// Testbench for the flash self-program access guard
`timescale 1ns/1ns
`default_nettype none
`include "fspag_consts.svh"
module tb;
logic mclk_i = 1'b0;
logic sys_rst_i = 1'b1;
logic [1:0] bsz = 2'h3;
logic vib = 1'b0;
logic [1:0] lkm = 2'h0;
logic pset = 1'b0;
logic [3:0] pdat = 4'hf;
logic cer = 1'b0;
logic [6:0] pc = 7'h7e;
fspag_pkg::fspag_req_type req = '0;
logic lreq = 1'b0;
logic [6:0] lpg = 7'h0;
logic [6:0] fpg = 7'h0;
logic [7:0] lat = 8'h6;
logic done, acc, rfs, lal, fal, stl, irq, bsy;
logic [1:0] ap, bp;
fspag_pkg::fspag_req_type cmd;
logic [6:0] bst [4] = '{`FSPAG_BOOT_PAGE_SZ0, `FSPAG_BOOT_PAGE_SZ1, `FSPAG_BOOT_PAGE_SZ2, `FSPAG_BOOT_PAGE_SZ3};
int fail_count = 0;
int checked = 0;
always #50 mclk_i = ~mclk_i;
fspag_guard dut_u (.mclk_i, .sys_rst_i, .boot_size_setting_i(bsz), .vectors_in_boot_i(vib), .lock_mode_i(lkm),
	.prot_set_i(pset), .prot_data_i(pdat), .chip_erase_i(cer), .pc_page_i(pc), .spm_req_i(req), .lpm_req_i(lreq),
	.lpm_page_i(lpg), .fetch_page_i(fpg), .flash_done_i(done), .spm_accept_o(acc), .spm_refuse_o(rfs),
	.flash_cmd_o(cmd), .lpm_allow_o(lal), .fetch_allow_o(fal), .cpu_stall_o(stl), .irq_mask_o(irq),
	.region_busy_flag_o(bsy), .app_protect_o(ap), .boot_protect_o(bp));
fspag_flash_model fm_u (.mclk_i, .sys_rst_i, .cmd_i(cmd), .lat_i(lat), .done_o(done));
task step;
	@(posedge mclk_i);
	#1;
endtask : step
task chk(input logic [7:0] g, input logic [7:0] e);
	checked++;
	if (g !== e)
	begin
		fail_count++;
		$display("MISMATCH %0t got %h exp %h", $time, g, e);
	end
endtask : chk
// Op codes: 0 load, 1 erase, 2 write, 3 reenable
task store_program_instruction(input logic [1:0] op, input logic [6:0] pg, input logic e);
	req = '{1'b1, fspag_pkg::fspag_op_type'(op), pg};
	step;
	req.valid = 1'b0;
	chk({acc, rfs}, {e, !e});
	// One idle edge, so back-to-back calls never raise valid where it just fell
	step;
endtask : store_program_instruction
task lpm(input logic [6:0] pg, input logic e);
	lreq = 1'b1;
	lpg = pg;
	step;
	lreq = 1'b0;
	chk(lal, e);
endtask : lpm
task wdone;
	for (int n = 0; n < 300 && done !== 1'b1; n++) step;
	chk(done, 1'b1);
	step;
endtask : wdone
task prot(input logic [3:0] d);
	pdat = d;
	pset = 1'b1;
	step;
	pset = 1'b0;
endtask : prot
task end_of_test;
	if (fail_count == 0 && checked > 0)
		$display("All checks passed");
	else
		$display("Checks failed");
	$finish;
endtask : end_of_test
initial
begin
	repeat (5) step;
	sys_rst_i = 1'b0;
	chk({ap, bp, bsy, stl, fal}, 8'h79);
	for (int s = 0; s < 4; s++)
	begin
		bsz = 2'(s);
		pc = bst[s];
		store_program_instruction(2'h0, 7'h0, 1'b1);
		pc = bst[s] - 7'h1;
		store_program_instruction(2'h0, 7'h0, 1'b0);
	end
	store_program_instruction(2'h1, 7'h10, 1'b0);
	pc = 7'h7e;
	vib = 1'b1;
	store_program_instruction(2'h1, 7'h10, 1'b1);
	chk({bsy, stl}, 2'h2);
	fpg = 7'h10;
	step;
	chk(fal, 1'b0);
	fpg = 7'h60;
	step;
	chk(fal, 1'b1);
	store_program_instruction(2'h3, 7'h0, 1'b0);
	wdone;
	chk(bsy, 1'b1);
	fpg = 7'h10;
	store_program_instruction(2'h3, 7'h0, 1'b1);
	repeat (2) step;
	chk({bsy, fal}, 2'h1);
	store_program_instruction(2'h2, 7'h11, 1'b1);
	wdone;
	store_program_instruction(2'h0, 7'h0, 1'b1);
	repeat (2) step;
	chk(bsy, 1'b0);
	lat = 8'h40;
	lkm = 2'h3;
	store_program_instruction(2'h2, 7'h7f, 1'b1);
	chk({stl, fal}, 2'h2);
	repeat (30) step;
	chk(stl, 1'b1);
	wdone;
	chk({stl, fal}, 2'h1);
	lkm = 2'h2;
	lat = 8'h2;
	store_program_instruction(2'h1, 7'h7f, 1'b1);
	wdone;
	prot(4'he);
	chk({ap, bp}, 4'hb);
	store_program_instruction(2'h2, 7'h10, 1'b0);
	lpm(7'h10, 1'b1);
	prot(4'hc);
	lpm(7'h10, 1'b0);
	vib = 1'b1;
	pc = 7'h10;
	repeat (2) step;
	chk(irq, 1'b1);
	lpm(7'h7e, 1'b1);
	pc = 7'h7e;
	prot(4'h7);
	chk({ap, bp}, 4'h1);
	store_program_instruction(2'h2, 7'h7f, 1'b1);
	wdone;
	vib = 1'b0;
	repeat (2) step;
	chk(irq, 1'b1);
	pc = 7'h10;
	lpm(7'h7e, 1'b0);
	pc = 7'h7e;
	prot(4'hf);
	chk({ap, bp}, 4'h1);
	cer = 1'b1;
	step;
	cer = 1'b0;
	chk({ap, bp}, 4'hf);
	prot(4'hb);
	store_program_instruction(2'h2, 7'h7f, 1'b0);
	store_program_instruction(2'h2, 7'h10, 1'b1);
	wdone;
	end_of_test;
end
initial
begin
	#1000000;
	fail_count++;
	end_of_test;
end
endmodule : tb
`default_nettype wire
